// ==== rtl/port_pins_pkg.sv ====
// Constants, types and address decoding shared by the universal port block.
package port_pins_pkg;

    // Register indices; the bus byte address is four times the index.
    localparam logic [6:0] IDX_LEVEL_A = 7'h3C;
    localparam logic [6:0] IDX_LEVEL_B = 7'h7C;
    localparam logic [6:0] IDX_FLAGS_A = 7'h3D;
    localparam logic [6:0] IDX_FLAGS_B = 7'h7D;
    localparam logic [6:0] IDX_DIR_A   = 7'h3E;
    localparam logic [6:0] IDX_DIR_B   = 7'h7E;
    localparam logic [6:0] IDX_CFG_A   = 7'h39;
    localparam logic [6:0] IDX_CFG_B   = 7'h79;

    // Word address field of the Wishbone byte address.
    localparam int ADR_LSB   = 2;
    localparam int ADR_MSB   = 8;
    localparam int PORT_BITS = 8;

    // Reset values.
    localparam logic [7:0] DIR_RESET   = 8'hFF;
    localparam logic [7:0] MASK_RESET  = 8'hFF;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET   = 8'h00;

    // Field positions in irq_port_config.
    localparam int CFG_SHOW_BIT = 0;

    // One-hot register selection.
    typedef enum logic [4:0] {
        SEL_NONE  = 5'b00001,
        SEL_LEVEL = 5'b00010,
        SEL_FLAGS = 5'b00100,
        SEL_DIR   = 5'b01000,
        SEL_CFG   = 5'b10000
    } reg_sel_e;

    // Pin drive bundle: level and output enable.
    typedef struct packed {
        logic [PORT_BITS-1:0] level;
        logic [PORT_BITS-1:0] enable;
    } pin_drive_s;

    // Both channel windows map onto the same registers.
    function automatic reg_sel_e decode_sel(input logic [6:0] idx);
        case (idx)
            IDX_LEVEL_A, IDX_LEVEL_B: decode_sel = SEL_LEVEL;
            IDX_FLAGS_A, IDX_FLAGS_B: decode_sel = SEL_FLAGS;
            IDX_DIR_A, IDX_DIR_B:     decode_sel = SEL_DIR;
            IDX_CFG_A, IDX_CFG_B:     decode_sel = SEL_CFG;
            default:                  decode_sel = SEL_NONE;
        endcase
    endfunction : decode_sel

endpackage : port_pins_pkg

// ==== rtl/universal_port_pins.sv ====
// Eight-pin general-purpose port with change interrupts behind a Wishbone slave.
//
// Notes on behaviour
// - The pin level register answers at both channel addresses and both reach one register.
// - Bit n of the level, flag, mask and direction registers belongs to port pin n, for n from 0 to 7.
// - Reading the pin level register returns the level of all pins, inputs and outputs alike.
// - Writing the pin level register sets the driven value of output pins and input positions are ignored.
// - An event flag is set for any input pin that changes state, and an interrupt is raised only for an unmasked one.
// - Reading the event flag register clears the flags it returns.
// - A change on a masked input is kept pending and raises the interrupt once its mask bit is cleared, unless a flag read with show-masked set clears it.
// - With show-masked set, masked events appear in the flags but never drive the interrupt.
// - With show-masked clear, masked events do not appear when the flags are read.
// - Several changes on one pin before the flags are read give only one request.
// - Mask bit 0 enables a pin's interrupt, 1 disables it, and the mask resets to all ones.
// - The flags are read and the mask written at one address in both channel windows.
// - The mask is write-only and both channel addresses reach one shared register.
// - Direction bit 0 makes the pin an output and 1 makes it an input.
// - The direction register resets to all ones, so every pin starts as an input.
// - The direction register is readable and writable at both channel addresses.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps

module universal_port_pins
    import port_pins_pkg::*;
#(
    parameter int PINS = PORT_BITS
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [8:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Port pins
    input  wire logic [PINS-1:0] pin_i,
    output logic      [PINS-1:0] pin_o,
    output logic      [PINS-1:0] pin_oe_o,
    // Interrupt
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter check

    // Every register is one byte wide, so the port cannot exceed eight pins.
    if (PINS < 1 || PINS > PORT_BITS) begin : g_bad_pins
        $error("PINS must lie between 1 and 8");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic       [PINS-1:0] dir_reg;
    logic       [PINS-1:0] mask_reg;
    logic       [PINS-1:0] out_reg;
    logic       [PINS-1:0] pend_reg;
    logic       [PINS-1:0] pend_next;
    logic       [PINS-1:0] sync1_reg;
    logic       [PINS-1:0] sync2_reg;
    logic       [PINS-1:0] prev_reg;
    logic       [2:0]      warm_reg;
    logic       [PINS-1:0] oe_bits;
    logic       [PINS-1:0] change;
    logic       [PINS-1:0] visible;
    logic       [PINS-1:0] clr;
    logic                  show_reg;
    logic                  ack_reg;
    logic       [31:0]     rdata_reg;
    logic                  take;
    logic                  wr_take;
    logic                  rd_take;
    reg_sel_e              sel;
    pin_drive_s            drive;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // A request is taken once; the ack cycle itself is never taken again.
    assign take    = cyc_i && stb_i && !ack_reg;
    assign wr_take = take && we_i && sel_i[0];
    assign rd_take = take && !we_i;
    assign sel     = decode_sel(adr_i[ADR_MSB:ADR_LSB]);

    // Ack is registered, so every access answers exactly one cycle after it is taken.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
        end
    end

    assign ack_o = ack_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and change detection

    // Two flops guard against metastability; only the second feeds any logic.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // The chain resets to zero, so a pin that idles high would look like a change just after reset.
    // Detection therefore waits until prev_reg holds a real sample of the pin.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            warm_reg <= 3'h0;
        end else begin
            warm_reg <= {warm_reg[1:0], 1'b1};
        end
    end

    // A change counts only on pins configured as inputs, once the chain is primed.
    assign change = (sync2_reg ^ prev_reg) & dir_reg & {PINS{warm_reg[2]}};

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Direction: all pins start as inputs so nothing is driven before software says so.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            dir_reg <= DIR_RESET[PINS-1:0];
        end else if (wr_take && sel == SEL_DIR) begin
            dir_reg <= dat_i[PINS-1:0];
        end
    end

    // Mask: write-only, shares its address with the read-side event flags.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mask_reg <= MASK_RESET[PINS-1:0];
        end else if (wr_take && sel == SEL_FLAGS) begin
            mask_reg <= dat_i[PINS-1:0];
        end
    end

    // Output levels: only bits of output pins take the written value.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_reg <= LEVEL_RESET[PINS-1:0];
        end else if (wr_take && sel == SEL_LEVEL) begin
            out_reg <= (dat_i[PINS-1:0] & ~dir_reg) | (out_reg & dir_reg);
        end
    end

    // Port configuration holds the show-masked setting.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            show_reg <= CFG_RESET[CFG_SHOW_BIT];
        end else if (wr_take && sel == SEL_CFG) begin
            show_reg <= dat_i[CFG_SHOW_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event flags

    // Masked pending events stay hidden unless show-masked is set.
    assign visible = pend_reg & (~mask_reg | {PINS{show_reg}});
    assign clr     = (rd_take && sel == SEL_FLAGS) ? visible : '0;

    // Per pin: a change sets, a read of a shown flag clears, and the set wins.
    // A hidden masked flag survives the read so it can fire once unmasked.
    for (genvar n = 0; n < PINS; n++) begin : g_pend
        assign pend_next[n] = change[n] | (pend_reg[n] & ~clr[n]);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // Only unmasked flags raise the interrupt; masked ones never do.
    assign irq_o = |(pend_reg & ~mask_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    // Read data is captured when the request is taken and stands with ack.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            rdata_reg <= 32'h0000_0000;
            case (sel)
                SEL_LEVEL: rdata_reg[PINS-1:0] <= sync2_reg;
                SEL_FLAGS: rdata_reg[PINS-1:0] <= visible;
                SEL_DIR:   rdata_reg[PINS-1:0] <= dir_reg;
                SEL_CFG:   rdata_reg[CFG_SHOW_BIT] <= show_reg;
                default:   rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign dat_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive

    // Output enable follows the direction register straight from its flops.
    // The inversion is taken at pin width first, so unused upper bits of the bundle stay zero.
    assign oe_bits  = ~dir_reg;
    assign drive    = '{level: PORT_BITS'(out_reg), enable: PORT_BITS'(oe_bits)};
    assign pin_o    = drive.level[PINS-1:0];
    assign pin_oe_o = drive.enable[PINS-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_ack_single;
        @(posedge clk_i) disable iff (reset_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held longer than one cycle");

    property p_ack_follows;
        @(posedge clk_i) disable iff (reset_i)
        take |=> ack_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("taken request not acked next cycle");

    property p_level_read;
        @(posedge clk_i) disable iff (reset_i)
        (rd_take && sel == SEL_LEVEL) |=> dat_o[PINS-1:0] == $past(sync2_reg);
    endproperty
    a_level_read: assert property (p_level_read) else $error("level read differs from pins");

    property p_level_write;
        @(posedge clk_i) disable iff (reset_i)
        (wr_take && sel == SEL_LEVEL)
        |=> pin_o == (($past(dat_i[PINS-1:0]) & ~$past(dir_reg)) | ($past(out_reg) & $past(dir_reg)));
    endproperty
    a_level_write: assert property (p_level_write) else $error("input positions took written level");

    property p_no_output_event;
        @(posedge clk_i) disable iff (reset_i)
        (pend_reg & ~$past(pend_reg) & ~$past(dir_reg)) == '0;
    endproperty
    a_no_output_event: assert property (p_no_output_event) else $error("flag set on an output pin");

    property p_read_clears;
        @(posedge clk_i) disable iff (reset_i)
        (rd_take && sel == SEL_FLAGS && change == '0) |=> (pend_reg & $past(visible)) == '0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear flags");

    property p_unmask_fires;
        @(posedge clk_i) disable iff (reset_i)
        (wr_take && sel == SEL_FLAGS && |(pend_reg & ~dat_i[PINS-1:0])) |=> irq_o;
    endproperty
    a_unmask_fires: assert property (p_unmask_fires) else $error("pending event lost on unmask");

    property p_masked_hidden;
        @(posedge clk_i) disable iff (reset_i)
        (rd_take && sel == SEL_FLAGS && !show_reg) |=> (dat_o[PINS-1:0] & $past(mask_reg)) == '0;
    endproperty
    a_masked_hidden: assert property (p_masked_hidden) else $error("masked flag shown");

    property p_masked_quiet;
        @(posedge clk_i) disable iff (reset_i)
        (mask_reg == '1) |-> !irq_o;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("interrupt with all masked");

    property p_oe_dir;
        @(posedge clk_i) disable iff (reset_i)
        (wr_take && sel == SEL_DIR) |=> pin_oe_o == ~$past(dat_i[PINS-1:0]) ##1 pin_oe_o == $past(pin_oe_o);
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("output enable does not follow direction");

    ////////////////////////////////////////////////////////////////////////////
    // Reset, synchroniser and flag lifetime assertions

    // The reset-value check watches the first edge after any reset, so a mid-run reset is covered as well.
    property p_reset_values;
        @(posedge clk_i) disable iff (reset_i)
        $fell(reset_i) |-> dir_reg == DIR_RESET[PINS-1:0] && mask_reg == MASK_RESET[PINS-1:0] && !show_reg;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("register not at reset value");

    property p_sync_delay;
        @(posedge clk_i) disable iff (reset_i)
        warm_reg[2] |-> sync2_reg == $past(pin_i, 2);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("synchronised level lags wrongly");

    property p_change_sets;
        @(posedge clk_i) disable iff (reset_i)
        (change != '0) |=> (pend_reg & $past(change)) == $past(change);
    endproperty
    a_change_sets: assert property (p_change_sets) else $error("input change did not set its flag");

    property p_flag_holds;
        @(posedge clk_i) disable iff (reset_i)
        ($past(pend_reg) & ~$past(clr) & ~pend_reg) == '0;
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag dropped without a read");

    ////////////////////////////////////////////////////////////////////////////
    // Register access assertions

    // Read data is checked against the state at the taken edge, not against the bench.
    property p_flag_read_value;
        @(posedge clk_i) disable iff (reset_i)
        (rd_take && sel == SEL_FLAGS && !show_reg) |=> dat_o[PINS-1:0] == $past(pend_reg & ~mask_reg);
    endproperty
    a_flag_read_value: assert property (p_flag_read_value) else $error("flag read not unmasked flags");

    property p_show_read;
        @(posedge clk_i) disable iff (reset_i)
        (rd_take && sel == SEL_FLAGS && show_reg) |=> dat_o[PINS-1:0] == $past(pend_reg);
    endproperty
    a_show_read: assert property (p_show_read) else $error("shown flags incomplete");

    property p_read_drops_irq;
        @(posedge clk_i) disable iff (reset_i)
        (rd_take && sel == SEL_FLAGS && change == '0) |=> !irq_o;
    endproperty
    a_read_drops_irq: assert property (p_read_drops_irq) else $error("interrupt survives flag read");

    property p_mask_write;
        @(posedge clk_i) disable iff (reset_i)
        (wr_take && sel == SEL_FLAGS) |=> mask_reg == $past(dat_i[PINS-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write not stored");

    property p_mask_read_keeps;
        @(posedge clk_i) disable iff (reset_i)
        (rd_take && sel == SEL_FLAGS) |=> $stable(mask_reg);
    endproperty
    a_mask_read_keeps: assert property (p_mask_read_keeps) else $error("flag read changed the mask");

    property p_dir_read;
        @(posedge clk_i) disable iff (reset_i)
        (rd_take && sel == SEL_DIR) |=> dat_o[PINS-1:0] == $past(dir_reg);
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read differs");

    property p_level_hold;
        @(posedge clk_i) disable iff (reset_i)
        !(wr_take && sel == SEL_LEVEL) |=> $stable(pin_o);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("driven level changed without a write");

    // A write without the low byte lane is acked but must leave every register alone.
    property p_lane_off;
        @(posedge clk_i) disable iff (reset_i)
        (take && we_i && !sel_i[0])
        |=> $stable(dir_reg) && $stable(mask_reg) && $stable(out_reg) && $stable(show_reg);
    endproperty
    a_lane_off: assert property (p_lane_off) else $error("write without low byte lane stored");

    property p_upper_zero;
        @(posedge clk_i) disable iff (reset_i)
        ack_o |-> dat_o[31:PORT_BITS] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read data bits not zero");

    c_pin_event:  cover property (@(posedge clk_i) disable iff (reset_i) $rose(irq_o));
    c_flag_read:  cover property (@(posedge clk_i) disable iff (reset_i) rd_take && sel == SEL_FLAGS && visible != '0);
    c_unmask:     cover property (@(posedge clk_i) disable iff (reset_i)
                                  wr_take && sel == SEL_FLAGS && |(pend_reg & mask_reg) ##1 irq_o);
    c_show_read:  cover property (@(posedge clk_i) disable iff (reset_i)
                                  rd_take && sel == SEL_FLAGS && show_reg && (visible & mask_reg) != '0);
    c_lane_off:   cover property (@(posedge clk_i) disable iff (reset_i) take && we_i && !sel_i[0]);

endmodule : universal_port_pins

// ==== testbench/pin_partner.sv ====
// Far-side model of the eight port pins: external drivers plus wire feedback.
`timescale 1ns/1ps

module pin_partner (
    // Design side
    input  wire logic [7:0] drive_i,
    input  wire logic [7:0] enable_i,
    // Bench side
    input  wire logic [7:0] ext_i,
    output logic      [7:0] level_o
);
    // A driven pin reads back its own level, so the external source never fights the port.
    always_comb begin
        level_o = (drive_i & enable_i) | (ext_i & ~enable_i);
    end
endmodule : pin_partner

// ==== testbench/tb_top.sv ====
// Self-checking bench for the universal port block.
`timescale 1ns/1ps

module tb_top;
    import port_pins_pkg::*;

    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [8:0]  adr = 9'h000;
    logic [3:0]  sel = 4'hF;
    logic [31:0] dat = 32'h00000000;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [7:0]  pin_i;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe_o;
    logic        irq_o;
    logic [7:0]  ext = 8'h00;
    int          fails = 0;
    int          num_checks = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock toggles every half period of 5 ns.
    always #5 clk_i = ~clk_i;

    universal_port_pins i_dut (.clk_i(clk_i), .reset_i(reset_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o));

    pin_partner i_pins (.drive_i(pin_o), .enable_i(pin_oe_o), .ext_i(ext), .level_o(pin_i));

    ////////////////////////////////////////////////////////////////////////
    // Compares one value and counts the outcome.
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One classic cycle; it holds the request until ack is sampled high, and only the watchdog ends a hang.
    task automatic bus(input logic w, input logic [8:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h000000, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] e, input string what);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(what, q, {24'h000000, e});
    endtask : rd

    // Waits whole cycles so the pin synchronisers and flags settle.
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask : idle

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(9'h0F8, 8'hFF, "dir after reset");
        chk("oe after reset", pin_oe_o, 8'h00);
        ext <= 8'h08;
        idle(6);
        chk("irq with reset mask", irq_o, 1'b0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_port();
        wr(9'h1F8, 8'hF0);
        rd(9'h0F8, 8'hF0, "dir other window");
        chk("oe", pin_oe_o, 8'h0F);
        ext <= 8'h30;
        wr(9'h0F0, 8'hA5);
        idle(4);
        chk("driven outputs", pin_o & pin_oe_o, 8'h05);
        rd(9'h1F0, 8'h35, "level all pins");
        $display("test port done");
    endtask : t_port

    task automatic t_events();
        logic [31:0] q;
        wr(9'h0F8, 8'hFF);
        idle(5);
        // Show-masked lets one read drop every stale event left by earlier tests.
        wr(9'h0E4, 8'h01);
        bus(1'b0, 9'h0F4, 8'h00, q);
        wr(9'h0E4, 8'h00);
        wr(9'h1F4, 8'hFE);
        ext <= ext ^ 8'h03;
        idle(5);
        ext <= ext ^ 8'h01;
        idle(5);
        chk("irq unmasked change", irq_o, 1'b1);
        rd(9'h0F4, 8'h01, "flags hide masked");
        chk("irq after read", irq_o, 1'b0);
        rd(9'h1F4, 8'h00, "flags cleared");
        wr(9'h1F4, 8'hFC);
        idle(1);
        chk("irq pending released", irq_o, 1'b1);
        rd(9'h0F4, 8'h02, "pending flag");
        $display("test events done");
    endtask : t_events

    task automatic t_show();
        wr(9'h1E4, 8'h01);
        wr(9'h0F4, 8'hFF);
        ext <= ext ^ 8'h04;
        idle(5);
        chk("irq masked shown", irq_o, 1'b0);
        rd(9'h1F4, 8'h04, "masked shown");
        rd(9'h0F4, 8'h00, "shown cleared");
        rd(9'h000, 8'h00, "unmapped");
        sel <= 4'hE;
        wr(9'h0F8, 8'h00);
        sel <= 4'hF;
        rd(9'h0F8, 8'hFF, "dir lane off");
        $display("test show done");
    endtask : t_show

    // A reset with pins held high must not leave a false change behind.
    task automatic t_rearm();
        reset_i <= 1'b1;
        idle(2);
        reset_i <= 1'b0;
        wr(9'h0F4, 8'h00);
        idle(4);
        chk("irq after reset with pins high", irq_o, 1'b0);
        ext <= ext ^ 8'h80;
        idle(5);
        chk("irq event after reset", irq_o, 1'b1);
        rd(9'h1F4, 8'h80, "event after reset");
        $display("test rearm done");
    endtask : t_rearm

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // Main sequence after a four-cycle reset.
    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_port();
        t_events();
        t_show();
        t_rearm();
        print_verdict();
    end

    // Watchdog sized well beyond the roughly 120 cycles the tests need.
    initial begin
        repeat (3000) @(posedge clk_i);
        fails++;
        print_verdict();
    end
endmodule : tb_top
